// ### stage_follower.sv
// far-side model: speed selector and run sequencing watching run/stage
// assumes the sequencer's clock and reset
`timescale 1ns/1ps
`default_nettype none
module stage_follower (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic [2:0]  stage,
    output var  logic [7:0]  rises,
    output var  logic [2:0]  rise_stage,
    output var  logic [15:0] run_len
);
    logic        run_d;   // run one clock ago
    logic [15:0] len_cnt; // clocks of the current run
    // count run requests, note stage picked, time each run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_d <= 1'b0;
            rises <= 8'h00;
            rise_stage <= 3'h0;
            len_cnt <= 16'h0000;
            run_len <= 16'h0000;
        end else begin
            run_d <= run;
            len_cnt <= run ? len_cnt + 16'h0001 : 16'h0000;
            if (run && !run_d) begin // selector latches stage on run
                rises <= rises + 8'h01;
                rise_stage <= stage;
            end
            if (!run && run_d) run_len <= len_cnt;
        end
    end
endmodule // stage_follower
`default_nettype wire

// ### staged_run_defs.vh
// constants for the staged run sequencer: defaults, widths, tick timing
// assumes the includer sets up a single 25 MHz clock domain
`ifndef STAGED_RUN_DEFS_VH
`define STAGED_RUN_DEFS_VH
`define MAX_STAGES          4'h8
`define MIN_STAGES          4'h2
`define DEF_STAGES          4'h8
`define DEF_CYCLES          16'h0000
`define DEF_RUN_TENTHS      15'h000A
`define MIN_RUN_TENTHS      15'h0001
`define MAX_TENTHS          15'h7530
`define DEF_STOP_TENTHS     15'h0000
`define TICK_PERIOD_NS      100000000
`define CLK_PERIOD_NS       40
// tick period in clocks, 100 ms at 40 ns, kept at the time-base counter width
`define TICK_CYCLES         24'h2625A0
`endif

// ### staged_run_sequencer.v
// staged run sequencer: times run/stop per stage, counts cycles
// assumes settings come from same-clock logic; start comes from a pin and is synchronised
`timescale 1ns/1ps
`default_nettype none
`include "staged_run_defs.vh"
module staged_run_sequencer #(
    parameter [23:0] TICK_CYCLES = `TICK_CYCLES
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire         start,
    input  wire         resume,
    input  wire [3:0]   stages,
    input  wire [15:0]  cycles,
    input  wire         hold_last,
    input  wire [119:0] run_tenths,
    input  wire [119:0] stop_tenths,
    output reg          run,
    output reg  [2:0]   stage,
    output reg  [31:0]  cycle
);
    // behaviour in brief:
    // - idle until the synchronised start is seen high
    // - each stage times its running phase, then its stop phase
    // - a stop time of zero still costs one clock with run low
    // - the time base restarts at every phase change, so a phase of
    //   n tenths lasts exactly n full tick periods plus one clock
    // - a free-running time base would cut the first tenth of a phase
    //   short; restarting it trades a clock per phase for exact times
    // - after the last stage the index wraps and the cycle count climbs
    // - with a nonzero cycle count the walk ends in the done state
    // - hold_last keeps run high at the last stage once all cycles end;
    //   the final cycle is counted as it ends in either case
    // - dropping start in any phase returns to idle with run low
    // - the stage and cycle position survive idle for a resumed start
    // - resume is only looked at on the idle to run step
    // - done drops the stored position once start falls
    // limitations:
    // - settings are read live; changing them mid-phase takes effect
    //   at once, which can end a phase early
    // - times are whole tenths; fractions must be rounded by the user
    // - out-of-range settings are clamped, never refused
    //
    // state codes
    localparam [1:0] ST_IDLE = 2'h0; // waiting for start
    localparam [1:0] ST_RUN  = 2'h1; // running duration
    localparam [1:0] ST_STOP = 2'h2; // stop duration
    localparam [1:0] ST_DONE = 2'h3; // all cycles finished

    reg         start_s1_reg;  // first sync stage
    reg         start_s2_reg;  // second sync stage
    reg  [1:0]  state_reg;     // sequencer state
    reg  [1:0]  state_next;
    reg  [2:0]  idx_reg;       // remembered stage position
    reg  [2:0]  idx_next;
    reg  [31:0] cyc_reg;       // remembered elapsed cycles
    reg  [31:0] cyc_next;
    reg  [14:0] tim_reg;       // tenths elapsed in current phase
    reg  [14:0] tim_next;
    reg         run_next;
    reg  [2:0]  stage_next;
    wire        tick;          // 0.1 s time base
    wire [3:0]  n_stages;      // clamped stage count
    wire [14:0] run_sel [0:7]; // per-stage running time, clamped
    wire [14:0] stop_sel [0:7];// per-stage stop time, clamped
    wire [14:0] run_lim;
    wire [14:0] stop_lim;
    wire        last_stage;
    wire        last_cycle;
    wire        tick_run;      // time base enable, low on phase change

    // out-of-range stage counts clamp into 2..8
    assign n_stages = (stages < `MIN_STAGES) ? `MIN_STAGES :
                      (stages > `MAX_STAGES) ? `MAX_STAGES : stages;

    // per-stage times clamped into their legal ranges
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_time
            wire [14:0] r = run_tenths[g*15 +: 15];
            wire [14:0] s = stop_tenths[g*15 +: 15];
            assign run_sel[g]  = (r < `MIN_RUN_TENTHS) ? `MIN_RUN_TENTHS :
                                 (r > `MAX_TENTHS) ? `MAX_TENTHS : r;
            assign stop_sel[g] = (s > `MAX_TENTHS) ? `MAX_TENTHS : s;
        end
    endgenerate

    assign run_lim    = run_sel[idx_reg];
    assign stop_lim   = stop_sel[idx_reg];
    assign last_stage = ({1'b0, idx_reg} == n_stages - 4'h1);
    // zero cycles never reaches a last cycle
    assign last_cycle = (cycles != `DEF_CYCLES) &&
                        (cyc_reg + 32'h1 >= {16'h0000, cycles});

    tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .run_en (tick_run),
        .tick   (tick)
    );

    // restart the time base on every phase change so each phase is whole ticks
    assign tick_run = start_s2_reg && (state_reg != ST_IDLE) &&
                      (state_next == state_reg);

    // start arrives from outside; two flops before use
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_s1_reg <= 1'b0;
            start_s2_reg <= 1'b0;
        end else if (ce) begin
            start_s1_reg <= start;
            start_s2_reg <= start_s1_reg;
        end
    end

    // next-state logic for the stage walk
    always @* begin
        state_next = state_reg;
        idx_next   = idx_reg;
        cyc_next   = cyc_reg;
        tim_next   = tim_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_s2_reg) begin
                    state_next = ST_RUN;
                    tim_next   = 15'h0000;
                    if (!resume) begin
                        idx_next = 3'h0;
                        cyc_next = 32'h0;
                    end
                end
            end
            ST_RUN: begin
                if (!start_s2_reg) begin
                    state_next = ST_IDLE;
                end else if (tick) begin
                    if (tim_reg + 15'h0001 >= run_lim) begin
                        tim_next = 15'h0000;
                        if (last_stage && last_cycle && hold_last) begin
                            state_next = ST_DONE;
                            cyc_next   = cyc_reg + 32'h1;
                        end else if (stop_lim == 15'h0000) begin
                            state_next = ST_STOP; // zero stop passes in one cycle
                        end else begin
                            state_next = ST_STOP;
                        end
                    end else begin
                        tim_next = tim_reg + 15'h0001;
                    end
                end
            end
            ST_STOP: begin
                if (!start_s2_reg) begin
                    state_next = ST_IDLE;
                end else if ((stop_lim == 15'h0000) ||
                             (tick && (tim_reg + 15'h0001 >= stop_lim))) begin
                    tim_next = 15'h0000;
                    if (last_stage) begin
                        cyc_next = cyc_reg + 32'h1;
                        idx_next = 3'h0;
                        state_next = last_cycle ? ST_DONE : ST_RUN;
                    end else begin
                        idx_next   = idx_reg + 3'h1;
                        state_next = ST_RUN;
                    end
                end else if (tick) begin
                    tim_next = tim_reg + 15'h0001;
                end
            end
            ST_DONE: begin
                // finished: stays until start drops; position resets for fresh start
                if (!start_s2_reg) begin
                    state_next = ST_IDLE;
                    idx_next   = 3'h0;
                    cyc_next   = 32'h0;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // output values derived from the coming state
    always @* begin
        run_next   = (state_next == ST_RUN) ||
                     ((state_next == ST_DONE) && hold_last);
        stage_next = (state_next == ST_IDLE) ? 3'h0 : idx_next;
    end

    // state and output registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            idx_reg   <= 3'h0;
            cyc_reg   <= 32'h0;
            tim_reg   <= 15'h0000;
            run       <= 1'b0;
            stage     <= 3'h0;
            cycle     <= 32'h0;
        end else if (ce) begin
            state_reg <= state_next;
            idx_reg   <= idx_next;
            cyc_reg   <= cyc_next;
            tim_reg   <= tim_next;
            run       <= run_next;
            stage     <= stage_next;
            cycle     <= cyc_next;
        end
    end
endmodule // staged_run_sequencer
`default_nettype wire

// ### staged_run_sequencer_checker.sv
// assertions on the staged run sequencer ports
// assumes one clock domain, async active-low reset, bound below
`timescale 1ns/1ps
`default_nettype none
module staged_run_checker #(
    parameter [23:0] TICK_CYCLES = 24'h000004
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        start,
    input wire logic        resume,
    input wire logic [15:0] cycles,
    input wire logic        hold_last,
    input wire logic        run,
    input wire logic [2:0]  stage,
    input wire logic [31:0] cycle
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // outputs clear straight out of reset
    property p_reset; $rose(rst_n) |-> !run && stage == 3'h0 && cycle == 32'h0; endproperty
    // stages only climb by one or wrap
    property p_stage; $changed(stage) |-> stage == $past(stage) + 3'h1 || stage == 3'h0; endproperty
    // cycle count climbs by one or clears
    property p_cycle; $changed(cycle) |-> cycle == $past(cycle) + 32'h1 || cycle == 32'h0; endproperty
    // shortest run is one tick; four clocks matches the bench tick
    property p_run_min; $rose(run) |-> run[*4]; endproperty
    // halted start leaves run low at stage zero
    property p_halt; (!start && ce)[*5] |-> !run && stage == 3'h0; endproperty
    // a fresh start launches the run request
    property p_launch; (!start && ce)[*4] ##1 (start && ce && !resume)[*5] |-> run; endproperty
    // after the final cycle run follows the hold setting
    property p_done; $changed(cycle) && cycle == {16'h0, cycles} && cycles != 16'h0
        |-> ##1 (run == hold_last)[*3]; endproperty
    // clock enable low freezes every output
    property p_freeze; !ce |=> $stable(run) && $stable(stage) && $stable(cycle); endproperty
    a_reset: assert property (p_reset) else $error("outputs not clear");
    a_stage: assert property (p_stage) else $error("stage out of order");
    a_cycle: assert property (p_cycle) else $error("cycle jump");
    a_run_min: assert property (p_run_min) else $error("run too short");
    a_halt: assert property (p_halt) else $error("no halt");
    a_launch: assert property (p_launch) else $error("no launch");
    a_done: assert property (p_done) else $error("bad end state");
    a_freeze: assert property (p_freeze) else $error("moved while frozen");
    c_run: cover property ($rose(run));
    c_wrap: cover property ($changed(cycle) && cycle != 32'h0);
    c_freeze: cover property (!ce ##1 ce);
endmodule // staged_run_checker
bind staged_run_sequencer staged_run_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .start(start), .resume(resume), .cycles(cycles),
    .hold_last(hold_last), .run(run), .stage(stage), .cycle(cycle));
`default_nettype wire

// ### tb_staged_run_sequencer.sv
// bench: scenario calls with expected values on the staged run sequencer
// assumes checker and follower compiled first; tick shortened to 4 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_staged_run_sequencer;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, start = 1'b0, resume = 1'b0, hold_last = 1'b0;
    logic [3:0] stages = 4'h8;
    logic [15:0] cycles = 16'h0000;
    logic [119:0] run_tenths, stop_tenths;
    wire run;
    wire [2:0] stage, rise_stage;
    wire [31:0] cycle;
    wire [7:0] rises;
    wire [15:0] run_len;
    int err_count = 0, checks = 0;
    staged_run_sequencer #(.TICK_CYCLES(24'h000004)) uut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .start(start), .resume(resume), .stages(stages), .cycles(cycles), .hold_last(hold_last),
        .run_tenths(run_tenths), .stop_tenths(stop_tenths), .run(run), .stage(stage), .cycle(cycle));
    stage_follower far (.clk(clk), .rst_n(rst_n), .run(run), .stage(stage), .rises(rises),
        .rise_stage(rise_stage), .run_len(run_len));
    always #20 clk = ~clk;
    // stage n runs n+1 ticks; only stage 0 has a stop of one tick
    initial for (int i = 0; i < 8; i++) begin
        run_tenths[15*i +: 15] = 15'(i + 1);
        stop_tenths[15*i +: 15] = (i == 0) ? 15'h0001 : 15'h0000;
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // bounded wait for the cycle output to reach a count
    task automatic wait_cycle(input logic [31:0] tgt);
        int n;
        n = 0;
        while (cycle !== tgt && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) begin
            check("wait", tgt, cycle);
            test_done();
        end
    endtask
    // idle, set up, start, then judge the state three clocks after target
    task automatic run_case(input logic [3:0] st, input logic [15:0] cy, input logic hl,
        input logic [31:0] tgt, input logic [7:0] n_exp, input logic [2:0] s_exp, input logic r_exp);
        logic [7:0] r0;
        @(posedge clk);
        start <= 1'b0;
        resume <= 1'b0;
        stages <= st;
        cycles <= cy;
        hold_last <= hl;
        repeat (6) @(posedge clk);
        r0 = rises;
        start <= 1'b1;
        wait_cycle(tgt);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("rises", {24'h0, n_exp}, {24'h0, rises - r0});
        check("run", {31'h0, r_exp}, {31'h0, run});
        check("stage", {29'h0, s_exp}, {29'h0, stage});
        @(posedge clk);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("cycle", 32'h0, cycle);
        run_case(4'h2, 16'h0, 1'b0, 32'h3, 8'h07, 3'h0, 1'b1);
        start <= 1'b0;
        repeat (8) @(posedge clk);
        check("run", 32'h0, {31'h0, run});
        resume <= 1'b1;
        start <= 1'b1;
        repeat (8) @(posedge clk);
        check("cycle", 32'h3, cycle);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        run_case(4'h3, 16'h2, 1'b0, 32'h2, 8'h06, 3'h0, 1'b0);
        check("run_len", 32'hD, {16'h0, run_len});
        run_case(4'h3, 16'h1, 1'b1, 32'h1, 8'h03, 3'h2, 1'b1);
        check("rise_stage", 32'h2, {29'h0, rise_stage});
        run_case(4'h1, 16'h1, 1'b0, 32'h1, 8'h02, 3'h0, 1'b0);
        run_case(4'hF, 16'h1, 1'b0, 32'h1, 8'h08, 3'h0, 1'b0);
        rst_n <= 1'b0;
        @(posedge clk);
        check("cycle", 32'h0, cycle);
        test_done();
    end
endmodule // tb_staged_run_sequencer
`default_nettype wire

// ### tick_gen.v
// time-base tick generator: one-cycle pulse every tick_cycles clocks
// assumes the same clock and reset as its parent
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter [23:0] TICK_CYCLES = 24'h2625A0
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ce,
    input  wire        run_en,
    output reg         tick
);
    reg [23:0] cnt_reg; // cycles within the current tick period

    // free count; held at zero while not running so the first tick is a full period
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 24'h000000;
            tick    <= 1'b0;
        end else if (ce) begin
            if (!run_en) begin
                cnt_reg <= 24'h000000;
                tick    <= 1'b0;
            end else if (cnt_reg == TICK_CYCLES - 24'h000001) begin
                cnt_reg <= 24'h000000;
                tick    <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 24'h000001;
                tick    <= 1'b0;
            end
        end
    end
endmodule // tick_gen
`default_nettype wire
